// ==== verilog/rlg_pkg.sv ====
/*
  Shared constants for the gated multidrop serial link: character framing,
  bit timing and the idle mark and gate-off figures.
  Assumes a single 100 MHz system clock shared by both ends.
*/
package rlg_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned DEF_BAUD        = 9600;
  localparam int unsigned BIT_CYC_DEF     = CLK_HZ / DEF_BAUD;
  localparam int unsigned CNT_W           = 20;
  localparam int unsigned IDLE_MARK_CHARS = 2;
  localparam int unsigned LINK_EXTRA_CHARS = 1;
  localparam int unsigned GATE_OFF_BITS_NUM = 1;
  localparam int unsigned GATE_OFF_BITS_DEN = 2;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned BIT_IDX_W       = 4;
  localparam logic        MARK_LVL        = 1'b1;
  localparam logic        SPACE_LVL       = 1'b0;
  localparam logic [BIT_IDX_W-1:0] FRAME_BASE_BITS = 4'h2;
  localparam logic [BIT_IDX_W-1:0] BIT_ZERO = 4'h0;
  localparam logic [1:0]  CHAR_ZERO       = 2'h0;
  localparam logic [7:0]  DEF_LEAD_CHAR   = 8'h05;
endpackage

// ==== verilog/rlg_link_if.sv ====
/*
  Differential multidrop link between the serial module and a target.
  Each end drives its transmit pair only with its own enable high; the
  bench resolves the receive pair from peer_tx_oe, and the target end masks the device pair with tx_oe.
*/
`timescale 1ns/1ns
interface rlg_link_if;
  logic tx_pair_positive;
  logic tx_pair_negative;
  logic tx_oe;
  logic rx_pair_positive;
  logic rx_pair_negative;
  logic peer_tx_positive;
  logic peer_tx_negative;
  logic peer_tx_oe;

  modport serial_comm_module (
    output tx_pair_positive,
    output tx_pair_negative,
    output tx_oe,
    input  rx_pair_positive,
    input  rx_pair_negative
  );

  modport target (
    input  tx_pair_positive,
    input  tx_pair_negative,
    input  tx_oe,
    output peer_tx_positive,
    output peer_tx_negative,
    output peer_tx_oe
  );
endinterface

// ==== verilog/rlg_serial_comm_module.sv ====
/*
  Device end: gated serial transmitter and receiver for a multidrop port.
  Assumes a target that drives its pair only while it sends, and a user
  that holds tx_data steady while tx_valid is high until tx_ready.
*/
`timescale 1ns/1ns
// What this block and the target end do
// R1 - Send serial data only on transmit pair.
// R2 - Receive serial data from receive pair.
// R3 - Enable asserted means transmit pair driven low-impedance.
// R4 - Enable deasserted means pair released, nothing sent.
// R5 - Send two idle mark characters before data.
// R6 - Release driver under one bit after end.
// R7 - Targets enable drivers only while sending.
// R8 - Driver enable toggles automatically around each frame.
// R9 - Linked channels hold enable one extra character.
// R10 - Targets discard parity or framing error characters.
// R11 - Targets ignore characters until leading character.
// R12 - Keep driver on through final stop bits.
module rlg_serial_comm_module
  import rlg_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYC_DEF
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              parity_en,
  input  wire logic              parity_odd,
  input  wire logic              two_stop,
  input  wire logic              linked_mode,
  input  wire logic [DATA_W-1:0] tx_data,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  output logic                   tx_busy,
  output logic [DATA_W-1:0]      rx_data,
  output logic                   rx_valid,
  output logic                   rx_err,
  rlg_link_if.serial_comm_module link
);
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_BIT = CNT_W'(BIT_CYC / 2);
  localparam logic [CNT_W-1:0] GATE_OFF_CYC =
    CNT_W'((BIT_CYC * GATE_OFF_BITS_NUM) / GATE_OFF_BITS_DEN);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  typedef enum {TX_OFF, TX_MARK, TX_SEND, TX_HOLD, TX_GATE} rlg_tx_st_t;

  rlg_tx_st_t             st_ff, nxt_st;
  logic [CNT_W-1:0]       cnt_ff, nxt_cnt;
  logic [BIT_IDX_W-1:0]   bit_ff, nxt_bit;
  logic [1:0]             chr_ff, nxt_chr;
  logic [DATA_W+2:0]      sh_ff, nxt_sh;
  logic                   oe_ff, nxt_oe;
  logic                   line_ff, nxt_line;
  logic                   rdy_ff, nxt_rdy;
  logic [BIT_IDX_W-1:0]   frame_bits;

  always_comb begin
    frame_bits = FRAME_BASE_BITS + BIT_IDX_W'(DATA_W)
               + BIT_IDX_W'(parity_en) + BIT_IDX_W'(two_stop);
  end

  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_bit  = bit_ff;
    nxt_chr  = chr_ff;
    nxt_sh   = sh_ff;
    nxt_oe   = oe_ff;
    nxt_line = line_ff;
    nxt_rdy  = 1'b0;
    case (st_ff)
      TX_OFF: begin
        nxt_line = MARK_LVL;
        if (tx_valid) begin
          nxt_st  = TX_MARK; // [R8]
          nxt_oe  = 1'b1;    // [R3]
          nxt_cnt = CNT_ZERO;
          nxt_bit = BIT_ZERO;
          nxt_chr = CHAR_ZERO;
        end
      end
      TX_MARK: begin
        nxt_line = MARK_LVL; // [R5]
        nxt_cnt  = cnt_ff + 1'b1;
        if (cnt_ff == BIT_LAST) begin
          nxt_cnt = CNT_ZERO;
          nxt_bit = bit_ff + 1'b1;
          if (bit_ff == frame_bits - 1'b1) begin
            nxt_bit = BIT_ZERO;
            nxt_chr = chr_ff + 1'b1;
            if (chr_ff == 2'(IDLE_MARK_CHARS - 1)) begin // [R5]
              nxt_st = TX_SEND;
              nxt_rdy = 1'b1;
              nxt_sh = {MARK_LVL, MARK_LVL,
                        parity_odd ^ (^tx_data), tx_data};
              if (!parity_en)
                nxt_sh = {MARK_LVL, MARK_LVL, MARK_LVL, tx_data};
              nxt_line = SPACE_LVL;
            end
          end
        end
      end
      TX_SEND: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == BIT_LAST) begin
          nxt_cnt = CNT_ZERO;
          nxt_bit = bit_ff + 1'b1;
          if (bit_ff == frame_bits - 1'b1) begin // [R12]
            nxt_bit = BIT_ZERO;
            if (tx_valid) begin
              nxt_rdy = 1'b1;
              nxt_sh = {MARK_LVL, MARK_LVL,
                        parity_odd ^ (^tx_data), tx_data};
              if (!parity_en)
                nxt_sh = {MARK_LVL, MARK_LVL, MARK_LVL, tx_data};
              nxt_line = SPACE_LVL;
            end else if (linked_mode) begin
              nxt_st = TX_HOLD; // [R9]
              nxt_chr = CHAR_ZERO;
              nxt_line = MARK_LVL;
            end else begin
              nxt_st = TX_GATE; // [R6]
              nxt_line = MARK_LVL;
            end
          end else begin
            nxt_line = sh_ff[0]; // [R1]
            nxt_sh = {MARK_LVL, sh_ff[DATA_W+2:1]};
          end
        end
      end
      TX_HOLD: begin
        nxt_line = MARK_LVL;
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == BIT_LAST) begin
          nxt_cnt = CNT_ZERO;
          nxt_bit = bit_ff + 1'b1;
          if (bit_ff == frame_bits - 1'b1) begin
            nxt_bit = BIT_ZERO;
            nxt_chr = chr_ff + 1'b1;
            if (chr_ff == 2'(LINK_EXTRA_CHARS - 1)) begin // [R9]
              nxt_st = TX_OFF;
              nxt_oe = 1'b0;
            end
          end
        end
      end
      TX_GATE: begin
        nxt_line = MARK_LVL;
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff >= GATE_OFF_CYC) begin // [R6]
          nxt_st = TX_OFF;
          nxt_oe = 1'b0; // [R4]
          nxt_cnt = CNT_ZERO;
        end
      end
      default: begin
        nxt_st = TX_OFF;
        nxt_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_ff   <= TX_OFF;
      cnt_ff  <= CNT_ZERO;
      bit_ff  <= BIT_ZERO;
      chr_ff  <= CHAR_ZERO;
      sh_ff   <= '1;
      oe_ff   <= 1'b0;
      line_ff <= MARK_LVL;
      rdy_ff  <= 1'b0;
    end else if (clk_en) begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      bit_ff  <= nxt_bit;
      chr_ff  <= nxt_chr;
      sh_ff   <= nxt_sh;
      oe_ff   <= nxt_oe;
      line_ff <= nxt_line;
      rdy_ff  <= nxt_rdy;
    end
  end

  assign link.tx_pair_positive = line_ff;  // [R1]
  assign link.tx_pair_negative = ~line_ff; // [R1]
  assign link.tx_oe            = oe_ff;    // [R3] [R4]
  assign tx_ready              = rdy_ff;
  assign tx_busy               = oe_ff;

  // Receiver: three-stage sync; a level counts once stages 2 and 3 agree.
  typedef enum {RX_IDLE, RX_RUN} rlg_rx_st_t;
  logic [2:0]             sync_ff;
  logic                   rxl_ff, nxt_rxl;
  rlg_rx_st_t             rst_ff, nxt_rst;
  logic [CNT_W-1:0]       rcnt_ff, nxt_rcnt;
  logic [BIT_IDX_W-1:0]   rbit_ff, nxt_rbit;
  logic [DATA_W+1:0]      rsh_ff, nxt_rsh;
  logic [DATA_W-1:0]      rdat_ff, nxt_rdat;
  logic                   rv_ff, nxt_rv;
  logic                   re_ff, nxt_re;
  logic                   diff_in;
  logic [BIT_IDX_W-1:0]   rx_bits;

  assign diff_in = link.rx_pair_positive & ~link.rx_pair_negative; // [R2]
  assign rx_bits = frame_bits - BIT_IDX_W'(two_stop);

  always_comb begin
    nxt_rxl  = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : rxl_ff;
    nxt_rst  = rst_ff;
    nxt_rcnt = rcnt_ff;
    nxt_rbit = rbit_ff;
    nxt_rsh  = rsh_ff;
    nxt_rdat = rdat_ff;
    nxt_rv   = 1'b0;
    nxt_re   = re_ff;
    case (rst_ff)
      RX_IDLE: begin
        if (rxl_ff == SPACE_LVL) begin
          nxt_rst  = RX_RUN;
          nxt_rcnt = HALF_BIT;
          nxt_rbit = BIT_ZERO;
        end
      end
      RX_RUN: begin
        nxt_rcnt = rcnt_ff + 1'b1;
        if (rcnt_ff == BIT_LAST) begin
          nxt_rcnt = CNT_ZERO;
          nxt_rbit = rbit_ff + 1'b1;
          nxt_rsh  = {rxl_ff, rsh_ff[DATA_W+1:1]};
          if (rbit_ff == rx_bits - 1'b1) begin
            nxt_rst = RX_IDLE;
            nxt_rv  = 1'b1;
            if (parity_en) begin
              nxt_rdat = rsh_ff[DATA_W:1];
              nxt_re = (rxl_ff != MARK_LVL) ||
                       ((^rsh_ff[DATA_W+1:1]) != parity_odd);
            end else begin
              nxt_rdat = rsh_ff[DATA_W+1:2];
              nxt_re = (rxl_ff != MARK_LVL);
            end
          end
        end
      end
      default: nxt_rst = RX_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync_ff <= {3{MARK_LVL}};
      rxl_ff  <= MARK_LVL;
      rst_ff  <= RX_IDLE;
      rcnt_ff <= CNT_ZERO;
      rbit_ff <= BIT_ZERO;
      rsh_ff  <= '0;
      rdat_ff <= '0;
      rv_ff   <= 1'b0;
      re_ff   <= 1'b0;
    end else if (clk_en) begin
      sync_ff <= {sync_ff[1:0], diff_in};
      rxl_ff  <= nxt_rxl;
      rst_ff  <= nxt_rst;
      rcnt_ff <= nxt_rcnt;
      rbit_ff <= nxt_rbit;
      rsh_ff  <= nxt_rsh;
      rdat_ff <= nxt_rdat;
      rv_ff   <= nxt_rv;
      re_ff   <= nxt_re;
    end
  end

  assign rx_data  = rdat_ff;
  assign rx_valid = rv_ff;
  assign rx_err   = re_ff;
endmodule

// ==== verilog/rlg_target_end.sv ====
/*
  Far end: a target station on the multidrop line. It receives frames,
  drops bad or unaligned characters, and drives only while replying.
  Assumes the same framing as the device end and one shared clock.
*/
`timescale 1ns/1ns
module rlg_target_end
  import rlg_pkg::*;
#(
  parameter int unsigned BIT_CYC   = BIT_CYC_DEF,
  parameter logic [7:0]  LEAD_CHAR = DEF_LEAD_CHAR
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              parity_odd,
  input  wire logic [DATA_W-1:0] reply_data,
  input  wire logic              reply_valid,
  output logic                   reply_ready,
  output logic [DATA_W-1:0]      got_data,
  output logic                   got_valid,
  rlg_link_if.target             link
);
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_BIT = CNT_W'(BIT_CYC / 2);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [BIT_IDX_W-1:0] FR_BITS =
    FRAME_BASE_BITS + BIT_IDX_W'(DATA_W) + 4'h1;

  typedef enum {T_IDLE, T_RUN} rlg_trx_st_t;
  logic [2:0]           sync_ff;
  logic                 rxl_ff, nxt_rxl;
  rlg_trx_st_t          st_ff, nxt_st;
  logic [CNT_W-1:0]     cnt_ff, nxt_cnt;
  logic [BIT_IDX_W-1:0] bit_ff, nxt_bit;
  logic [DATA_W+1:0]    sh_ff, nxt_sh;
  logic                 aligned_ff, nxt_aligned;
  logic [DATA_W-1:0]    dat_ff, nxt_dat;
  logic                 v_ff, nxt_v;
  logic                 good;
  logic [DATA_W-1:0]    rx_char;

  always_comb begin
    nxt_rxl = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : rxl_ff;
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_aligned = aligned_ff;
    nxt_dat = dat_ff;
    nxt_v = 1'b0;
    rx_char = sh_ff[DATA_W:1];
    good = (rxl_ff == MARK_LVL) && ((^sh_ff[DATA_W+1:1]) == parity_odd);
    case (st_ff)
      T_IDLE: begin
        if (rxl_ff == SPACE_LVL) begin
          nxt_st = T_RUN;
          nxt_cnt = HALF_BIT;
          nxt_bit = BIT_ZERO;
        end
      end
      T_RUN: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == BIT_LAST) begin
          nxt_cnt = CNT_ZERO;
          nxt_bit = bit_ff + 1'b1;
          nxt_sh = {rxl_ff, sh_ff[DATA_W+1:1]};
          if (bit_ff == FR_BITS - 1'b1) begin
            nxt_st = T_IDLE;
            if (good) begin // [R10]
              if (aligned_ff || rx_char == LEAD_CHAR) begin // [R11]
                nxt_aligned = 1'b1;
                nxt_dat = rx_char;
                nxt_v = 1'b1;
              end
            end else begin
              nxt_aligned = 1'b0; // [R10]
            end
          end
        end
      end
      default: nxt_st = T_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync_ff <= {3{MARK_LVL}};
      rxl_ff <= MARK_LVL;
      st_ff <= T_IDLE;
      cnt_ff <= CNT_ZERO;
      bit_ff <= BIT_ZERO;
      sh_ff <= '0;
      aligned_ff <= 1'b0;
      dat_ff <= '0;
      v_ff <= 1'b0;
    end else if (clk_en) begin
      sync_ff <= {sync_ff[1:0], link.tx_pair_positive & ~link.tx_pair_negative
                  & link.tx_oe};
      rxl_ff <= nxt_rxl;
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      aligned_ff <= nxt_aligned;
      dat_ff <= nxt_dat;
      v_ff <= nxt_v;
    end
  end

  assign got_data = dat_ff;
  assign got_valid = v_ff;

  // Reply transmitter: driver on only across its own characters.
  logic                 toe_ff, nxt_toe;
  logic                 tl_ff, nxt_tl;
  logic [CNT_W-1:0]     tcnt_ff, nxt_tcnt;
  logic [BIT_IDX_W-1:0] tbit_ff, nxt_tbit;
  logic [DATA_W+1:0]    tsh_ff, nxt_tsh;
  logic                 trdy_ff, nxt_trdy;

  always_comb begin
    nxt_toe = toe_ff;
    nxt_tl = tl_ff;
    nxt_tcnt = tcnt_ff;
    nxt_tbit = tbit_ff;
    nxt_tsh = tsh_ff;
    nxt_trdy = 1'b0;
    if (!toe_ff) begin
      nxt_tl = MARK_LVL;
      if (reply_valid) begin
        nxt_toe = 1'b1; // [R7] [R3]
        nxt_trdy = 1'b1;
        nxt_tl = SPACE_LVL;
        nxt_tsh = {MARK_LVL, parity_odd ^ (^reply_data), reply_data};
        nxt_tcnt = CNT_ZERO;
        nxt_tbit = BIT_ZERO;
      end
    end else begin
      nxt_tcnt = tcnt_ff + 1'b1;
      if (tcnt_ff == BIT_LAST) begin
        nxt_tcnt = CNT_ZERO;
        nxt_tbit = tbit_ff + 1'b1;
        nxt_tl = tsh_ff[0];
        nxt_tsh = {MARK_LVL, tsh_ff[DATA_W+1:1]};
        if (tbit_ff == FR_BITS - 1'b1) begin
          nxt_toe = 1'b0; // [R7] [R4]
          nxt_tl = MARK_LVL;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      toe_ff <= 1'b0;
      tl_ff <= MARK_LVL;
      tcnt_ff <= CNT_ZERO;
      tbit_ff <= BIT_ZERO;
      tsh_ff <= '1;
      trdy_ff <= 1'b0;
    end else if (clk_en) begin
      toe_ff <= nxt_toe;
      tl_ff <= nxt_tl;
      tcnt_ff <= nxt_tcnt;
      tbit_ff <= nxt_tbit;
      tsh_ff <= nxt_tsh;
      trdy_ff <= nxt_trdy;
    end
  end

  assign link.peer_tx_positive = tl_ff;
  assign link.peer_tx_negative = ~tl_ff;
  assign link.peer_tx_oe = toe_ff;
  assign reply_ready = trdy_ff;
endmodule

// ==== verif/rlg_link_sva.sv ====
/*
  Checker for the gated multidrop link: driver enables, idle marks,
  stop-bit hold and the peer's drive discipline.
  Assumes one clock and a synchronous active-high reset for both ends.
*/
`timescale 1ns/1ns
module rlg_link_sva
  import rlg_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYC_DEF
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic tx_pair_positive,
  input wire logic tx_pair_negative,
  input wire logic tx_oe,
  input wire logic peer_tx_positive,
  input wire logic peer_tx_negative,
  input wire logic peer_tx_oe
);
  // Two characters of the shortest frame, start plus eight plus stop.
  localparam int unsigned MIN_MARK = 20 * BIT_CYC;
  localparam int unsigned PEER_MAX = 11 * BIT_CYC + 1;

  int unsigned mark_cnt_ff;
  int unsigned nxt_mark_cnt;
  int unsigned hi_cnt_ff;
  int unsigned nxt_hi_cnt;
  int unsigned peer_cnt_ff;
  int unsigned nxt_peer_cnt;
  logic        seen_space_ff;
  logic        nxt_seen_space;

  always_comb begin
    nxt_seen_space = tx_oe && (seen_space_ff || !tx_pair_positive);
    nxt_mark_cnt   = (tx_oe && !seen_space_ff) ? mark_cnt_ff + 1 : 0;
    nxt_hi_cnt     = (tx_oe && tx_pair_positive) ? hi_cnt_ff + 1 : 0;
    nxt_peer_cnt   = peer_tx_oe ? peer_cnt_ff + 1 : 0;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      seen_space_ff <= 1'b0;
      mark_cnt_ff   <= 0;
      hi_cnt_ff     <= 0;
      peer_cnt_ff   <= 0;
    end else begin
      seen_space_ff <= nxt_seen_space;
      mark_cnt_ff   <= nxt_mark_cnt;
      hi_cnt_ff     <= nxt_hi_cnt;
      peer_cnt_ff   <= nxt_peer_cnt;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_DRV_COMPL: assert property (
    tx_oe |-> tx_pair_negative == !tx_pair_positive)
    else $error("transmit pair not complementary");
  AST_OFF_MARK: assert property (
    !tx_oe |-> tx_pair_positive && !tx_pair_negative)
    else $error("released pair not at mark");
  AST_IDLE_MARK: assert property (
    tx_oe && !tx_pair_positive && !seen_space_ff |-> mark_cnt_ff >= MIN_MARK)
    else $error("idle mark shorter than two characters");
  AST_STOP_KEPT: assert property (
    $fell(tx_oe) |-> hi_cnt_ff >= BIT_CYC)
    else $error("driver released before final stop bit ended");
  AST_BIT_HOLD: assert property (
    tx_oe && $changed(tx_pair_positive) |=> $stable(tx_pair_positive)[*8])
    else $error("driven bit shorter than expected");
  AST_OE_HELD: assert property (
    $rose(tx_oe) |-> (tx_oe && tx_pair_positive)[*8])
    else $error("enable did not open with mark");
  AST_PEER_START: assert property (
    $rose(peer_tx_oe) |-> !peer_tx_positive)
    else $error("peer enabled without sending a start bit");
  AST_PEER_LEN: assert property (
    peer_cnt_ff <= PEER_MAX)
    else $error("peer driver held beyond one character");
  AST_PEER_COMPL: assert property (
    peer_tx_oe |-> peer_tx_negative == !peer_tx_positive)
    else $error("peer pair not complementary");
  AST_RST_QUIET: assert property (disable iff (1'b0)
    $fell(sys_rst) |-> !tx_oe && !peer_tx_oe)
    else $error("driver enabled out of reset");

  COV_GATE_OFF: cover property ($fell(tx_oe));
  COV_PEER_TX: cover property ($rose(peer_tx_oe));
  COV_FIRST_START: cover property (tx_oe && $fell(tx_pair_positive));
endmodule

// ==== verif/tb_top.sv ====
/*
  Testbench joining the device end and the target end over the link.
  Assumes a pull-up on the receive pair while the target is released.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top;
  import rlg_pkg::*;
  localparam int unsigned BC = 16;
  logic              mclk, sys_rst, parity_en, parity_odd, two_stop;
  logic              linked_mode, tx_valid, tx_ready, tx_busy, rx_valid;
  logic              rx_err, tgt_odd, reply_valid, reply_ready, got_valid;
  logic [DATA_W-1:0] tx_data, rx_data, reply_data, got_data;
  logic [DATA_W-1:0] got_q[$];
  logic [DATA_W-1:0] send_q[$];
  logic              oe_q, first_sp;
  int                fail_count, n_tests, cyc, oe_rise, oe_fall;
  int                sp_cyc, rdy_cyc;

  rlg_link_if link();
  assign link.rx_pair_positive =
    link.peer_tx_oe ? link.peer_tx_positive : 1'b1;
  assign link.rx_pair_negative =
    link.peer_tx_oe ? link.peer_tx_negative : 1'b0;

  rlg_serial_comm_module #(.BIT_CYC(BC)) u_rlg_serial_comm_module (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .parity_en(parity_en),
    .parity_odd(parity_odd), .two_stop(two_stop),
    .linked_mode(linked_mode), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_busy(tx_busy), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_err(rx_err), .link(link));
  rlg_target_end #(.BIT_CYC(BC)) u_rlg_target_end (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .parity_odd(tgt_odd),
    .reply_data(reply_data), .reply_valid(reply_valid),
    .reply_ready(reply_ready), .got_data(got_data), .got_valid(got_valid),
    .link(link));
  rlg_link_sva #(.BIT_CYC(BC)) u_rlg_link_sva (
    .mclk(mclk), .sys_rst(sys_rst),
    .tx_pair_positive(link.tx_pair_positive),
    .tx_pair_negative(link.tx_pair_negative), .tx_oe(link.tx_oe),
    .peer_tx_positive(link.peer_tx_positive),
    .peer_tx_negative(link.peer_tx_negative), .peer_tx_oe(link.peer_tx_oe));

  always #5 mclk = ~mclk;

  // Records the cycle of each enable edge, first start bit and take.
  always @(posedge mclk) begin
    cyc++;
    if (link.tx_oe && !oe_q) begin
      oe_rise = cyc;
      first_sp = 1'b1;
    end
    if (!link.tx_oe && oe_q) oe_fall = cyc;
    if (link.tx_oe && !link.tx_pair_positive && first_sp) begin
      sp_cyc = cyc;
      first_sp = 1'b0;
    end
    if (tx_ready) rdy_cyc = cyc;
    if (got_valid) got_q.push_back(got_data);
    oe_q = link.tx_oe;
  end

  task complete_run();
    $display("Checks: %0d, mismatches: %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function logic sel(input int w);
    case (w)
      0: return tx_ready;
      1: return !link.tx_oe;
      2: return reply_ready;
      default: return rx_valid;
    endcase
  endfunction

  task automatic wait_on(input int w);
    for (int i = 0; i < 4000; i++) begin
      @(posedge mclk);
      if (sel(w) === 1'b1) return;
    end
    fail_count++;
    $display("[ERR] t=%0t wait %0d got=0 exp=1", $time, w);
    complete_run();
  endtask

  // Mode 0 expects nothing at the target, 1 checks, 2 skips.
  task automatic send_frame(input logic lk, pe, ts, po, input int mode);
    int fb;
    int gap;
    fb = 10 + int'(pe) + int'(ts);
    @(posedge mclk);
    linked_mode <= lk;
    parity_en <= pe;
    two_stop <= ts;
    parity_odd <= po;
    got_q.delete();
    foreach (send_q[i]) begin
      tx_data <= send_q[i];
      tx_valid <= 1'b1;
      wait_on(0);
    end
    tx_valid <= 1'b0;
    `CHK(tx_busy, 1'b1)
    wait_on(1);
    @(negedge mclk);
    `CHK(sp_cyc - oe_rise >= 2 * fb * BC, 1'b1)
    gap = oe_fall - (rdy_cyc + fb * BC);
    if (lk) `CHK(gap >= fb * BC - 1 && gap < (fb + 1) * BC, 1'b1)
    else `CHK(gap >= 0 && gap < BC, 1'b1)
    if (mode == 0) `CHK(got_q.size(), 0)
    if (mode == 1) begin
      `CHK(got_q[$], send_q[$])
      `CHK(got_q[0] !== send_q[0], 1'b1)
    end
  endtask

  task automatic reply(input logic [DATA_W-1:0] d, input logic todd);
    @(posedge mclk);
    tgt_odd <= todd;
    parity_en <= 1'b1;
    reply_data <= d;
    reply_valid <= 1'b1;
    wait_on(2);
    reply_valid <= 1'b0;
    wait_on(3);
    if (todd === parity_odd) `CHK(rx_data, d)
    `CHK(rx_err, todd !== parity_odd)
    `CHK(link.tx_oe, 1'b0)
  endtask

  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    {parity_en, parity_odd, two_stop, linked_mode} = 4'h0;
    {tx_valid, tgt_odd, reply_valid, oe_q, first_sp} = 5'h00;
    tx_data = 8'h00;
    reply_data = 8'h00;
    {fail_count, n_tests, cyc, oe_rise, oe_fall, sp_cyc, rdy_cyc} = '0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    send_q = '{8'h3C, 8'h05, 8'hA5};
    send_frame(1'b0, 1'b1, 1'b0, 1'b0, 1);
    send_q = '{8'h05, 8'h11};
    send_frame(1'b0, 1'b1, 1'b0, 1'b1, 0);
    send_q = '{8'hFF};
    send_frame(1'b1, 1'b0, 1'b1, 1'b0, 2);
    reply(8'h5A, 1'b0);
    reply(8'hC3, 1'b1);
    complete_run();
  end
endmodule
